// ### hw/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PFS_OFS_CTRL      4'h0
`define PFS_OFS_KEY       4'h1
`define PFS_OFS_ADDR_LO   4'h2
`define PFS_OFS_ADDR_HI   4'h3
`define PFS_OFS_DATA_LO   4'h4
`define PFS_OFS_DATA_HI   4'h5
`define PFS_OFS_IRQ_STAT  4'h6
`define PFS_OFS_IRQ_MASK  4'h7
// ----------------------------------------
// control field positions
// ----------------------------------------
`define PFS_BIT_READ      0
`define PFS_BIT_START     1
`define PFS_BIT_WALLOW    2
`define PFS_BIT_ERR       3
`define PFS_BIT_ERASE     4
`define PFS_BIT_LATCH     5
`define PFS_BIT_CFG       6
`define PFS_BIT_PMEM      7
// ----------------------------------------
// status bits
// ----------------------------------------
`define PFS_IRQ_DONE      0
`define PFS_IRQ_REJECT    1
// ----------------------------------------
// values and timing
// ----------------------------------------
`define PFS_KEY_FIRST     8'h55
`define PFS_KEY_SECOND    8'hAA
`define PFS_LATCH_RESET   14'h3FFF
`define PFS_CLK_HZ        40000000
`define PFS_OP_TIME_US    2000
`define PFS_OP_CYCLES     ((`PFS_OP_TIME_US * (`PFS_CLK_HZ / 1000000)))
`define PFS_SETUP_CYCLES  2
`endif

// ### hw/pfs_pkg.sv
package pfs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_LOAD,
        ST_ERASE,
        ST_PROG
    } pfs_state_t;

    typedef enum logic [1:0] {
        KEY_NONE,
        KEY_GOT55,
        KEY_ARMED
    } pfs_key_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfs_bus_t;

    typedef struct packed {
        logic        erase;
        logic        prog;
        logic [14:0] addr;
    } pfs_flash_cmd_t;
endpackage

// ### hw/pfs_sequencer.sv
// Notes on behaviour
// - program memory erases only in whole rows, never smaller pieces.
// - start only counts after 55h then AAh on the unlock register.
// - erase bit reads set during erase and clears when erase ends.
// - two setup cycles follow the start before the operation begins.
// - processor stalls about 2 ms during erase; clocks keep running.
// - execution resumes at the third instruction after the start.
// - a write never erases implicitly; software pre-erases targets.
// - at most one latch block of 32 words per programming operation.
// - latch block aligned on low address bits; never crosses a block.
// - all latches return to 3FFF after a program write completes.
// - latch-only-load set: start only stores data into the addressed latch.
// - latch-only-load clear: start loads last latch then programs whole block.
// - whole latch block programmed; unloaded latches keep their contents.
// - every latch load needs its own unlock and start; software steps address.
// - stall only on the final programming start, not on latch loads.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "pfs_consts.svh"
module pfs_sequencer #(
    parameter int LATCHES   = 32,
    parameter int OP_CYCLES = `PFS_OP_CYCLES
) (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_reset,
    input  wire pfs_pkg::pfs_bus_t       i_bus,
    output logic [7:0]                   o_rdata,
    output logic                         o_stall,
    output pfs_pkg::pfs_flash_cmd_t      o_flash_cmd,
    output logic [LATCHES*14-1:0]        o_latch_block,
    output logic                         o_irq
);
    localparam int AW = $clog2(LATCHES);

    typedef struct packed {
        pfs_pkg::pfs_state_t   state;
        pfs_pkg::pfs_key_t     key;
        logic [7:0]            ctrl;
        logic [14:0]           addr;
        logic [13:0]           data;
        logic [1:0]            irq_stat;
        logic [1:0]            irq_mask;
        logic [31:0]           count;
        logic [7:0]            rdata;
        logic                  stall;
        pfs_pkg::pfs_flash_cmd_t cmd;
        logic [LATCHES*14-1:0] latches;
    } pfs_regs_t;

    pfs_regs_t r;
    pfs_regs_t next_r;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic wr_ctrl;
        logic go;
        logic [AW-1:0] slot;
        wr_ctrl = i_bus.wr && (i_bus.addr == `PFS_OFS_CTRL);
        go = 1'b0;
        slot = r.addr[AW-1:0];
        next_r = r;
        next_r.rdata = 8'h00;
        next_r.cmd.erase = 1'b0;
        next_r.cmd.prog = 1'b0;
        if (i_bus.wr) begin
            case (i_bus.addr)
                `PFS_OFS_CTRL: begin
                    next_r.ctrl[7:2] = (r.state == pfs_pkg::ST_IDLE) ? i_bus.wdata[7:2] : r.ctrl[7:2];
                    next_r.ctrl[`PFS_BIT_READ] = 1'b0;
                end
                `PFS_OFS_KEY: begin
                    if (i_bus.wdata == `PFS_KEY_FIRST) begin
                        next_r.key = pfs_pkg::KEY_GOT55;
                    end else if (i_bus.wdata == `PFS_KEY_SECOND && r.key == pfs_pkg::KEY_GOT55) begin
                        next_r.key = pfs_pkg::KEY_ARMED;
                    end else begin
                        next_r.key = pfs_pkg::KEY_NONE;
                    end
                end
                `PFS_OFS_ADDR_LO: begin
                    next_r.addr[7:0] = i_bus.wdata;
                end
                `PFS_OFS_ADDR_HI: begin
                    next_r.addr[14:8] = i_bus.wdata[6:0];
                end
                `PFS_OFS_DATA_LO: begin
                    next_r.data[7:0] = i_bus.wdata;
                end
                `PFS_OFS_DATA_HI: begin
                    next_r.data[13:8] = i_bus.wdata[5:0];
                end
                `PFS_OFS_IRQ_MASK: begin
                    next_r.irq_mask = i_bus.wdata[1:0];
                end
                default: begin
                end
            endcase
            if (i_bus.addr != `PFS_OFS_KEY && !(wr_ctrl && i_bus.wdata[`PFS_BIT_START])) begin
                next_r.key = pfs_pkg::KEY_NONE;
            end
        end
        if (wr_ctrl && i_bus.wdata[`PFS_BIT_START] && !r.ctrl[`PFS_BIT_START]
            && r.state == pfs_pkg::ST_IDLE) begin
            next_r.key = pfs_pkg::KEY_NONE;
            if (r.key == pfs_pkg::KEY_ARMED && i_bus.wdata[`PFS_BIT_WALLOW]
                && i_bus.wdata[`PFS_BIT_PMEM] && !i_bus.wdata[`PFS_BIT_CFG]) begin
                go = 1'b1;
            end else begin
                next_r.ctrl[`PFS_BIT_ERR] = 1'b1;
                next_r.irq_stat[`PFS_IRQ_REJECT] = 1'b1;
            end
        end
        if (i_bus.wr && i_bus.addr == `PFS_OFS_IRQ_STAT) begin
            next_r.irq_stat = next_r.irq_stat & ~i_bus.wdata[1:0];
        end
        case (r.state)
            pfs_pkg::ST_IDLE: begin
                if (go) begin
                    next_r.ctrl[`PFS_BIT_START] = 1'b1;
                    next_r.count = 32'(`PFS_SETUP_CYCLES - 1);
                    next_r.state = pfs_pkg::ST_SETUP;
                end
            end
            pfs_pkg::ST_SETUP: begin
                if (r.count == 32'h00000000) begin
                    if (r.ctrl[`PFS_BIT_ERASE]) begin
                        next_r.state = pfs_pkg::ST_ERASE;
                        next_r.cmd.erase = 1'b1;
                        next_r.cmd.addr = {r.addr[14:AW], AW'(0)};
                        next_r.stall = 1'b1;
                        next_r.count = 32'(OP_CYCLES - 1);
                    end else begin
                        next_r.latches[slot*14 +: 14] = r.data;
                        if (r.ctrl[`PFS_BIT_LATCH]) begin
                            next_r.state = pfs_pkg::ST_LOAD;
                        end else begin
                            next_r.state = pfs_pkg::ST_PROG;
                            next_r.cmd.prog = 1'b1;
                            next_r.cmd.addr = {r.addr[14:AW], AW'(0)};
                            next_r.stall = 1'b1;
                            next_r.count = 32'(OP_CYCLES - 1);
                        end
                    end
                end else begin
                    next_r.count = r.count - 32'h00000001;
                end
            end
            pfs_pkg::ST_LOAD: begin
                next_r.ctrl[`PFS_BIT_START] = 1'b0;
                next_r.irq_stat[`PFS_IRQ_DONE] = 1'b1;
                next_r.state = pfs_pkg::ST_IDLE;
            end
            pfs_pkg::ST_ERASE, pfs_pkg::ST_PROG: begin
                if (r.count == 32'h00000000) begin
                    next_r.stall = 1'b0;
                    next_r.ctrl[`PFS_BIT_START] = 1'b0;
                    next_r.ctrl[`PFS_BIT_ERASE] = 1'b0;
                    next_r.irq_stat[`PFS_IRQ_DONE] = 1'b1;
                    if (r.state == pfs_pkg::ST_PROG) begin
                        next_r.latches = {LATCHES{`PFS_LATCH_RESET}};
                    end
                    next_r.state = pfs_pkg::ST_IDLE;
                end else begin
                    next_r.count = r.count - 32'h00000001;
                end
            end
            default: begin
                next_r.state = pfs_pkg::ST_IDLE;
            end
        endcase
        if (i_bus.rd) begin
            case (i_bus.addr)
                `PFS_OFS_CTRL:     next_r.rdata = r.ctrl;
                `PFS_OFS_ADDR_LO:  next_r.rdata = r.addr[7:0];
                `PFS_OFS_ADDR_HI:  next_r.rdata = {1'b0, r.addr[14:8]};
                `PFS_OFS_DATA_LO:  next_r.rdata = r.data[7:0];
                `PFS_OFS_DATA_HI:  next_r.rdata = {2'b00, r.data[13:8]};
                `PFS_OFS_IRQ_STAT: next_r.rdata = {6'h00, r.irq_stat};
                `PFS_OFS_IRQ_MASK: next_r.rdata = {6'h00, r.irq_mask};
                default:           next_r.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            r.state    <= pfs_pkg::ST_IDLE;
            r.key      <= pfs_pkg::KEY_NONE;
            r.ctrl     <= 8'h00;
            r.addr     <= 15'h0000;
            r.data     <= 14'h0000;
            r.irq_stat <= 2'h0;
            r.irq_mask <= 2'h0;
            r.count    <= 32'h00000000;
            r.rdata    <= 8'h00;
            r.stall    <= 1'b0;
            r.cmd      <= '0;
            r.latches  <= {LATCHES{`PFS_LATCH_RESET}};
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rdata       = r.rdata;
    assign o_stall       = r.stall;
    assign o_flash_cmd   = r.cmd;
    assign o_latch_block = r.latches;
    assign o_irq         = |(r.irq_stat & r.irq_mask);
endmodule // pfs_sequencer

// ### test/pfs_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// flash array model
// ----------------------------------------
module pfs_flash_model (
    input  wire logic                    i_ref_clk,
    input  wire pfs_pkg::pfs_flash_cmd_t i_cmd,
    input  wire logic [447:0]            i_block,
    output logic [447:0]                 o_last_block,
    output logic                         o_overwrite
);
    logic [1023:0] written = '0;
    initial o_overwrite = 1'b0;
    always @(posedge i_ref_clk) begin
        if (i_cmd.erase) written[i_cmd.addr[14:5]] <= 1'b0;
        if (i_cmd.prog) begin
            o_last_block <= i_block;
            written[i_cmd.addr[14:5]] <= 1'b1;
            if (written[i_cmd.addr[14:5]]) o_overwrite <= 1'b1;
        end
    end
endmodule // pfs_flash_model

// ### test/pfs_sequencer_asserts.sv
`timescale 1ns/10ps
module pfs_sequencer_asserts #(
    parameter int LATCHES   = 32,
    parameter int OP_CYCLES = 80000
) (
    input wire logic                    i_ref_clk,
    input wire logic                    i_reset,
    input wire pfs_pkg::pfs_bus_t       i_bus,
    input wire logic [7:0]              o_rdata,
    input wire logic                    o_stall,
    input wire pfs_pkg::pfs_flash_cmd_t o_flash_cmd,
    input wire logic [LATCHES*14-1:0]   o_latch_block,
    input wire logic                    o_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    int   n_stall;
    logic was_prog;
    always_ff @(posedge i_ref_clk) begin
        n_stall <= (i_reset || !o_stall) ? 0 : n_stall + 1;
        was_prog <= (i_reset || (!o_stall && !o_flash_cmd.prog)) ? 1'b0 : (was_prog || o_flash_cmd.prog);
    end
    sequence s_unlock;
        i_bus.wr && i_bus.addr == 4'h1 && i_bus.wdata == 8'h55 ##1
        i_bus.wr && i_bus.addr == 4'h1 && i_bus.wdata == 8'hAA ##1
        i_bus.wr && i_bus.addr == 4'h0 && i_bus.wdata[1] && !o_stall;
    endsequence
    AST_ERASE_START: assert property (s_unlock ##0 i_bus.wdata == 8'h96 |-> ##3 o_flash_cmd.erase)
        else $error("erase did not start after unlock");
    AST_LOAD_NO_STALL: assert property (s_unlock ##0 i_bus.wdata == 8'hA6 |=> !o_stall [*6])
        else $error("latch load stalled");
    AST_BAD_START: assert property (i_bus.wr && i_bus.addr == 4'h0 && i_bus.wdata[1] && !o_stall
        && !$past(i_bus.wr && i_bus.addr == 4'h1) |=> !o_stall [*5])
        else $error("start without unlock ran");
    AST_STALL_LEN: assert property ($fell(o_stall) |-> n_stall == OP_CYCLES)
        else $error("stall length wrong");
    AST_LATCH_CLEAR: assert property ($fell(o_stall) && was_prog |-> ##[0:2] o_latch_block == {LATCHES{14'h3FFF}})
        else $error("latches not cleared");
    AST_CMD_PULSE: assert property (o_flash_cmd.erase || o_flash_cmd.prog |-> o_stall
        ##1 !(o_flash_cmd.erase || o_flash_cmd.prog))
        else $error("command pulse without stall");
    AST_CMD_ALIGN: assert property (o_flash_cmd.erase || o_flash_cmd.prog |-> o_flash_cmd.addr[4:0] == 5'h00
        && !(o_flash_cmd.erase && o_flash_cmd.prog))
        else $error("command block misaligned");
    AST_READ_ZERO: assert property (i_bus.rd && (i_bus.addr == 4'h1 || i_bus.addr[3]) |=> o_rdata == 8'h00)
        else $error("key or unmapped read not zero");
endmodule // pfs_sequencer_asserts

// ### test/pfs_sequencer_test.sv
`timescale 1ns/10ps
module pfs_sequencer_test;
    localparam int OPC = 20;
    logic                    i_ref_clk = 1'b0;
    logic                    i_reset   = 1'b1;
    pfs_pkg::pfs_bus_t       bus       = '0;
    logic [7:0]              rdata;
    logic                    stall;
    logic                    irq;
    pfs_pkg::pfs_flash_cmd_t cmd;
    logic [447:0]            blk;
    logic [447:0]            last_blk;
    logic [447:0]            exp_blk;
    logic                    overwrite;
    int                      n_fail = 0;
    int                      checks = 0;
    pfs_sequencer #(.LATCHES(32), .OP_CYCLES(OPC)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(bus),
        .o_rdata(rdata), .o_stall(stall), .o_flash_cmd(cmd), .o_latch_block(blk), .o_irq(irq));
    pfs_flash_model u_flash (.i_ref_clk(i_ref_clk), .i_cmd(cmd), .i_block(blk), .o_last_block(last_blk),
        .o_overwrite(overwrite));
    always #12.5 i_ref_clk = ~i_ref_clk;
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [447:0] got, input logic [447:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // control value after a finished operation: start and erase cleared
    function automatic logic [7:0] ctrl_done(input logic [7:0] ctl);
        return ctl & 8'hED;
    endfunction
    // control value after a refused start: mode bits kept, reject flag set
    function automatic logic [7:0] ctrl_reject(input logic [7:0] ctl);
        return (ctl & 8'hFC) | 8'h08;
    endfunction
    task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge i_ref_clk);
    endtask
    task automatic idle(input int n);
        bus <= '0;
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        put(a, 8'h00, 1'b0);
        bus <= '0;
        #1 check(rdata, exp);
        @(posedge i_ref_clk);
    endtask
    task automatic start(input logic [7:0] ctl);
        put(4'h1, 8'h55, 1'b1);
        put(4'h1, 8'hAA, 1'b1);
        put(4'h0, ctl, 1'b1);
        idle(1);
    endtask
    task automatic run_op(output int n);
        n = 0;
        for (int k = 0; k < 8 && stall !== 1'b1; k++) @(posedge i_ref_clk) #1;
        if (stall !== 1'b1) begin
            check(stall, 1'b1);
            complete_run();
        end
        while (stall === 1'b1 && n < 100) begin
            n++;
            @(posedge i_ref_clk) #1;
        end
        if (n >= 100) begin
            check(n, OPC);
            complete_run();
        end
        @(posedge i_ref_clk);
    endtask
    initial begin
        int n;
        int base;
        int i;
        int w;
        int s;
        logic [13:0] d;
        void'($urandom(85));
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        check(blk, {32{14'h3FFF}});
        rd(4'h9, 8'h00);
        base = $urandom_range(1023) * 32;
        put(4'h2, base[7:0], 1'b1);
        put(4'h3, base[15:8], 1'b1);
        start(8'h96);
        idle(2);
        put(4'h0, 8'h00, 1'b1);
        rd(4'h0, 8'h96);
        run_op(n);
        rd(4'h0, ctrl_done(8'h96));
        exp_blk = {32{14'h3FFF}};
        w = $urandom_range(30, 1);
        for (i = 0; i <= w; i++) begin
            s = (i == w) ? 31 : i;
            d = 14'($urandom());
            exp_blk[s*14 +: 14] = d;
            put(4'h2, 8'(base + s), 1'b1);
            put(4'h3, 8'((base + s) >> 8), 1'b1);
            put(4'h4, d[7:0], 1'b1);
            put(4'h5, {2'b00, d[13:8]}, 1'b1);
            start(i == w ? 8'h86 : 8'hA6);
            if (i < w) begin
                idle(2);
                #1 check(stall, 1'b0);
                check(blk, exp_blk);
                @(posedge i_ref_clk);
            end
        end
        run_op(n);
        check(n, OPC);
        check(last_blk, exp_blk);
        check(blk, {32{14'h3FFF}});
        check(overwrite, 1'b0);
        put(4'h7, 8'h02, 1'b1);
        put(4'h0, 8'h96, 1'b1);
        put(4'h1, 8'h55, 1'b1);
        put(4'h2, 8'h00, 1'b1);
        put(4'h1, 8'hAA, 1'b1);
        put(4'h0, 8'h96, 1'b1);
        idle(4);
        #1 check(stall, 1'b0);
        check(irq, 1'b1);
        @(posedge i_ref_clk);
        rd(4'h6, 8'h03);
        rd(4'h0, ctrl_reject(8'h96));
        put(4'h6, 8'h03, 1'b1);
        idle(2);
        #1 check(irq, 1'b0);
        complete_run();
    end
endmodule // pfs_sequencer_test
bind pfs_sequencer pfs_sequencer_asserts #(.LATCHES(LATCHES), .OP_CYCLES(OP_CYCLES)) u_chk (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata), .o_stall(o_stall),
    .o_flash_cmd(o_flash_cmd), .o_latch_block(o_latch_block), .o_irq(o_irq));
